// file: xexec_defs.svh
`ifndef XEXEC_DEFS_SVH
`define XEXEC_DEFS_SVH

// Widths
`define XEXEC_DATA_W      8
`define XEXEC_PADDR_W     16
`define XEXEC_PAGE_W      8
`define XEXEC_DADDR_W     8

// Reset values, byte-set pattern and last page
`define XEXEC_WREG_RST    8'h00
`define XEXEC_TBL_RST     8'h00
`define XEXEC_FLAGS_RST   6'h00
`define XEXEC_ALL_ONES    8'hff
`define XEXEC_LAST_PAGE   8'hff

// Flag bit positions in the flag vector
`define XEXEC_FLG_SRANGE  0
`define XEXEC_FLG_Z       1
`define XEXEC_FLG_NIB     2
`define XEXEC_FLG_C       3
`define XEXEC_FLG_SCARRY  4
`define XEXEC_FLG_ZCHAIN  5

`endif

// file: xexec_pkg.sv
package xexec_pkg;

  // Operation select for the subset
  typedef enum logic [4:0] {
    OP_NONE       = 5'h00,
    OP_SBC_MEM    = 5'h01,
    OP_DSZ_MEM    = 5'h02,
    OP_DSZ_REG    = 5'h03,
    OP_SET_BYTE   = 5'h04,
    OP_SET_BIT    = 5'h05,
    OP_ISZ_MEM    = 5'h06,
    OP_ISZ_REG    = 5'h07,
    OP_SNZ_BIT    = 5'h08,
    OP_SNZ_BYTE   = 5'h09,
    OP_SUB_REG    = 5'h0a,
    OP_SUB_MEM    = 5'h0b,
    OP_SWAP_MEM   = 5'h0c,
    OP_SWAP_REG   = 5'h0d,
    OP_SZ_BYTE    = 5'h0e,
    OP_SZA        = 5'h0f,
    OP_SZ_BIT     = 5'h10,
    OP_TRD_CUR    = 5'h11,
    OP_TRD_LAST   = 5'h12,
    OP_TRD_INC    = 5'h13
  } op_t;

  // Issued instruction
  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [7:0]  addr;
    logic [2:0]  bit_sel;
    logic [7:0]  page;
  } instr_t;

  // Status flags: zero chain, signed carry, carry, nibble carry, zero, signed range
  typedef logic [5:0] flags_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_SKIP  = 2'b10
  } state_t;

  // Table-read engine state
  typedef struct packed {
    logic        busy;
    logic [7:0]  addr;
  } trd_t;

endpackage

// file: xexec_core.sv
`timescale 1ns/100ps
`include "xexec_defs.svh"

// Functional notes
// - SBC to memory: W minus m minus not-C
// - Subtracts update all six arithmetic flags
// - Taken skip inserts one dummy cycle
// - Decrement memory, skip when zero
// - Decrement into W, skip when zero
// - Byte set writes all ones
// - Bit set forces one bit high
// - Increment memory, skip when zero
// - Increment into W, skip when zero
// - Bit nonzero skip tests bit one
// - Byte nonzero skip when operand nonzero
// - Subtract into W, C low if negative
// - Subtract to memory, no borrow
// - Swap nibbles of memory in place
// - Swap nibbles into W only
// - Skip when operand equals zero
// - Copy to W, skip if zero
// - Bit zero skip tests bit zero
// - Table read within current page
// - Table read within last page
// - Preincrement pointer low, then read
// - Skip, set, swap, table keep flags
// - Pointer is high and low bytes
module xexec_core
(
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   srst_in,
  // Instruction issue
  input  wire xexec_pkg::instr_t      instr_in,
  // Data memory read (operand at instr_in.addr)
  input  wire logic [7:0]             mem_rdata_in,
  // Program memory
  input  wire logic [15:0]            prog_rdata_in,
  input  wire logic                   prog_rvalid_in,
  // Table pointer high byte, software owned
  input  wire logic [7:0]             table_pointer_high_byte_in,
  // Data memory write
  output logic                        mem_we_out,
  output logic [7:0]                  mem_waddr_out,
  output logic [7:0]                  mem_wdata_out,
  // Program memory read
  output logic                        prog_re_out,
  output logic [15:0]                 prog_addr_out,
  // Architectural state
  output logic [7:0]                  working_register_out,
  output logic [7:0]                  table_high_byte_register_out,
  output logic [7:0]                  table_pointer_low_byte_out,
  output xexec_pkg::flags_t           flags_out,
  // Sequencing
  output logic                        skip_out,
  output logic                        busy_out
);

  // -----------------------------------------------------------------
  // Subtractor
  // -----------------------------------------------------------------
  logic             sub_use_c;
  logic [7:0]       sub_res;
  xexec_pkg::flags_t sub_flags;

  xexec_sub u_sub
  (
    .a_in      (working_register_out),
    .b_in      (mem_rdata_in),
    .use_c_in  (sub_use_c),
    .flags_in  (flags_out),
    .res_out   (sub_res),
    .flags_out (sub_flags)
  );

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    xexec_pkg::state_t state;
    xexec_pkg::trd_t   trd;
    logic              mem_we;
    logic [7:0]        mem_waddr;
    logic [7:0]        mem_wdata;
    logic              prog_re;
    logic [15:0]       prog_addr;
    logic [7:0]        wreg;
    logic [7:0]        tab_hi;
    logic [7:0]        ptr_lo;
    xexec_pkg::flags_t flags;
    logic              skip;
    logic              busy;
  } core_t;

  core_t s_q;
  core_t s_d;

  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic [7:0] swp_v;
  logic       sel_bit;
  logic       issue;

  // Operand helpers
  assign dec_v   = mem_rdata_in - 8'h01;
  assign inc_v   = mem_rdata_in + 8'h01;
  assign swp_v   = {mem_rdata_in[3:0], mem_rdata_in[7:4]};
  assign sel_bit = mem_rdata_in[instr_in.bit_sel];
  assign issue   = instr_in.valid && (s_q.state == xexec_pkg::ST_IDLE);
  assign sub_use_c = (instr_in.op == xexec_pkg::OP_SBC_MEM);

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  // Flags change only on subtracts; all other ops leave s_d.flags alone
  always_comb
  begin
    s_d         = s_q;
    s_d.mem_we  = 1'b0;
    s_d.prog_re = 1'b0;
    s_d.skip    = 1'b0;
    case (s_q.state)
      xexec_pkg::ST_IDLE:
      begin
        if (issue)
        begin
          s_d.mem_waddr = instr_in.addr;
          case (instr_in.op)
            xexec_pkg::OP_SBC_MEM,
            xexec_pkg::OP_SUB_MEM:
            begin
              s_d.mem_we    = 1'b1;
              s_d.mem_wdata = sub_res;
              s_d.flags     = sub_flags;
            end
            xexec_pkg::OP_SUB_REG:
            begin
              s_d.wreg  = sub_res;
              s_d.flags = sub_flags;
            end
            xexec_pkg::OP_DSZ_MEM:
            begin
              s_d.mem_we    = 1'b1;
              s_d.mem_wdata = dec_v;
              s_d.skip      = (dec_v == 8'h00);
            end
            xexec_pkg::OP_DSZ_REG:
            begin
              s_d.wreg = dec_v;
              s_d.skip = (dec_v == 8'h00);
            end
            xexec_pkg::OP_ISZ_MEM:
            begin
              s_d.mem_we    = 1'b1;
              s_d.mem_wdata = inc_v;
              s_d.skip      = (inc_v == 8'h00);
            end
            xexec_pkg::OP_ISZ_REG:
            begin
              s_d.wreg = inc_v;
              s_d.skip = (inc_v == 8'h00);
            end
            xexec_pkg::OP_SET_BYTE:
            begin
              s_d.mem_we    = 1'b1;
              s_d.mem_wdata = `XEXEC_ALL_ONES;
            end
            xexec_pkg::OP_SET_BIT:
            begin
              s_d.mem_we    = 1'b1;
              s_d.mem_wdata = mem_rdata_in | (8'h01 << instr_in.bit_sel);
            end
            xexec_pkg::OP_SNZ_BIT:
              s_d.skip = sel_bit;
            xexec_pkg::OP_SNZ_BYTE:
              s_d.skip = (mem_rdata_in != 8'h00);
            xexec_pkg::OP_SZ_BYTE:
              s_d.skip = (mem_rdata_in == 8'h00);
            xexec_pkg::OP_SZ_BIT:
              s_d.skip = !sel_bit;
            xexec_pkg::OP_SZA:
            begin
              s_d.wreg = mem_rdata_in;
              s_d.skip = (mem_rdata_in == 8'h00);
            end
            xexec_pkg::OP_SWAP_MEM:
            begin
              s_d.mem_we    = 1'b1;
              s_d.mem_wdata = swp_v;
            end
            xexec_pkg::OP_SWAP_REG:
              s_d.wreg = swp_v;
            xexec_pkg::OP_TRD_CUR:
            begin
              s_d.prog_re   = 1'b1;
              s_d.prog_addr = {instr_in.page, s_q.ptr_lo};
              s_d.state     = xexec_pkg::ST_FETCH;
            end
            xexec_pkg::OP_TRD_LAST:
            begin
              s_d.prog_re   = 1'b1;
              s_d.prog_addr = {`XEXEC_LAST_PAGE, s_q.ptr_lo};
              s_d.state     = xexec_pkg::ST_FETCH;
            end
            xexec_pkg::OP_TRD_INC:
            begin
              s_d.ptr_lo    = s_q.ptr_lo + 8'h01;
              s_d.prog_re   = 1'b1;
              s_d.prog_addr = {table_pointer_high_byte_in, s_q.ptr_lo + 8'h01};
              s_d.state     = xexec_pkg::ST_FETCH;
            end
            default:
              s_d.skip = 1'b0;
          endcase
          if (s_d.skip)
            s_d.state = xexec_pkg::ST_SKIP;
          s_d.trd.busy = (s_d.state == xexec_pkg::ST_FETCH);
          s_d.trd.addr = instr_in.addr;
        end
      end
      xexec_pkg::ST_SKIP:
        s_d.state = xexec_pkg::ST_IDLE;
      xexec_pkg::ST_FETCH:
      begin
        if (prog_rvalid_in)
        begin
          s_d.mem_we    = 1'b1;
          s_d.mem_waddr = s_q.trd.addr;
          s_d.mem_wdata = prog_rdata_in[7:0];
          s_d.tab_hi    = prog_rdata_in[15:8];
          s_d.trd.busy  = 1'b0;
          s_d.state     = xexec_pkg::ST_IDLE;
        end
        else
        begin
          s_d.prog_re = 1'b1;
        end
      end
      default:
        s_d.state = xexec_pkg::ST_IDLE;
    endcase
    // Busy kept in a flop so the port needs no decode
    s_d.busy = (s_d.state != xexec_pkg::ST_IDLE);
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  // Synchronous reset to documented idle values
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      s_q           <= '0;
      s_q.state     <= xexec_pkg::ST_IDLE;
      s_q.wreg      <= `XEXEC_WREG_RST;
      s_q.tab_hi    <= `XEXEC_TBL_RST;
      s_q.ptr_lo    <= `XEXEC_TBL_RST;
      s_q.flags     <= `XEXEC_FLAGS_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign mem_we_out                   = s_q.mem_we;
  assign mem_waddr_out                = s_q.mem_waddr;
  assign mem_wdata_out                = s_q.mem_wdata;
  assign prog_re_out                  = s_q.prog_re;
  assign prog_addr_out                = s_q.prog_addr;
  assign working_register_out         = s_q.wreg;
  assign table_high_byte_register_out = s_q.tab_hi;
  assign table_pointer_low_byte_out   = s_q.ptr_lo;
  assign flags_out                    = s_q.flags;
  assign skip_out                     = s_q.skip;
  assign busy_out                     = s_q.busy;

endmodule

// file: xexec_sub.sv
`timescale 1ns/100ps
`include "xexec_defs.svh"

// Combinational subtractor with full flag set
module xexec_sub
(
  // Operands
  input  wire logic [7:0]             a_in,
  input  wire logic [7:0]             b_in,
  input  wire logic                   use_c_in,
  input  wire xexec_pkg::flags_t      flags_in,
  // Result
  output logic [7:0]                  res_out,
  output xexec_pkg::flags_t           flags_out
);

  logic       borrow_in;
  logic [8:0] full;
  logic [4:0] low;
  logic       zero;

  // Borrow is inverted carry, only for the with-carry form
  assign borrow_in = use_c_in & ~flags_in[`XEXEC_FLG_C];
  assign full = {1'b0, a_in} - {1'b0, b_in} - {8'h00, borrow_in};
  assign low  = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, borrow_in};
  assign res_out = full[7:0];
  assign zero    = (full[7:0] == 8'h00);

  // Carry high means no borrow; chained zero spans the carry form
  always_comb
  begin
    flags_out                    = flags_in;
    flags_out[`XEXEC_FLG_C]      = ~full[8];
    flags_out[`XEXEC_FLG_NIB]    = ~low[4];
    flags_out[`XEXEC_FLG_Z]      = zero;
    flags_out[`XEXEC_FLG_SRANGE] = (a_in[7] ^ b_in[7]) & (a_in[7] ^ full[7]);
    flags_out[`XEXEC_FLG_SCARRY] = flags_out[`XEXEC_FLG_SRANGE] ^ full[7];
    flags_out[`XEXEC_FLG_ZCHAIN] = use_c_in ? (zero & flags_in[`XEXEC_FLG_Z]) : zero;
  end

endmodule

// file: xexec_chk.sv
`timescale 1ns/100ps
// ----
// Port checks
// ----
module xexec_chk
(
  // Clock and reset
  input wire logic              mclk_in,
  input wire logic              srst_in,
  // Inputs
  input wire xexec_pkg::instr_t instr_in,
  input wire logic [7:0]        mem_rdata_in,
  input wire logic [15:0]       prog_rdata_in,
  input wire logic              prog_rvalid_in,
  // Outputs
  input wire logic              mem_we_out,
  input wire logic [7:0]        mem_wdata_out,
  input wire logic              prog_re_out,
  input wire logic [7:0]        working_register_out,
  input wire logic [7:0]        table_high_byte_register_out,
  input wire xexec_pkg::flags_t flags_out,
  input wire logic              skip_out,
  input wire logic              busy_out
);
  // Accepted opcode only, so a refused issue arms nothing
  wire logic [4:0] opc   = instr_in.valid && !busy_out ? instr_in.op : 5'h00;
  wire logic       bit_v = mem_rdata_in[instr_in.bit_sel];
  wire logic [2:0] bsel  = instr_in.bit_sel;
  wire logic [7:0] swp   = {mem_rdata_in[3:0], mem_rdata_in[7:4]};

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  byte_set_a:
    assert property (opc == xexec_pkg::OP_SET_BYTE |=> mem_we_out && mem_wdata_out == 8'hff
      && $stable(flags_out)) else $error("byte set bad");
  bit_set_a:
    assert property (opc == xexec_pkg::OP_SET_BIT |=> mem_we_out
      && mem_wdata_out == ($past(mem_rdata_in) | (8'h01 << $past(bsel)))) else $error("bit set bad");
  dec_skip_a:
    assert property (opc == xexec_pkg::OP_DSZ_MEM |=> mem_we_out
      && mem_wdata_out == $past(mem_rdata_in) - 8'h01 && skip_out == (mem_wdata_out == 8'h00))
      else $error("decrement skip bad");
  inc_reg_a:
    assert property (opc == xexec_pkg::OP_ISZ_REG |=> !mem_we_out
      && working_register_out == $past(mem_rdata_in) + 8'h01
      && skip_out == (working_register_out == 8'h00)) else $error("increment reg bad");
  swap_mem_a:
    assert property (opc == xexec_pkg::OP_SWAP_MEM |=> mem_we_out && mem_wdata_out == $past(swp)
      && $stable(flags_out)) else $error("swap bad");
  skip_dummy_a:
    assert property (skip_out |-> busy_out ##1 (!busy_out && !skip_out && !mem_we_out))
      else $error("skip cycle bad");
  bit_skip_a:
    assert property (opc == xexec_pkg::OP_SZ_BIT |=> skip_out != $past(bit_v))
      else $error("bit zero skip bad");
  table_word_a:
    assert property (prog_re_out && prog_rvalid_in |=> mem_we_out && $stable(flags_out)
      && {table_high_byte_register_out, mem_wdata_out} == $past(prog_rdata_in))
      else $error("table word bad");
endmodule

bind xexec_core xexec_chk xexec_chk_i
(
  .mclk_in (mclk_in), .srst_in (srst_in), .instr_in (instr_in),
  .mem_rdata_in (mem_rdata_in), .prog_rdata_in (prog_rdata_in),
  .prog_rvalid_in (prog_rvalid_in), .mem_we_out (mem_we_out), .mem_wdata_out (mem_wdata_out),
  .prog_re_out (prog_re_out), .working_register_out (working_register_out),
  .table_high_byte_register_out (table_high_byte_register_out),
  .flags_out (flags_out), .skip_out (skip_out), .busy_out (busy_out)
);

// file: xexec_mem_model.sv
`timescale 1ns/100ps
// ----
// Data and program memory
// ----
module xexec_mem_model
(
  // Clock
  input  wire logic        mclk_in,
  // Data memory
  input  wire logic [7:0]  rd_addr_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  waddr_in,
  input  wire logic [7:0]  wdata_in,
  output logic [7:0]       rdata_out,
  // Program memory
  input  wire logic        prog_re_in,
  input  wire logic [15:0] prog_addr_in,
  output logic [15:0]      prog_rdata_out,
  output logic             prog_rvalid_out
);
  logic [7:0] mem [256];

  // Identity fill puts zero, one and all ones at known places
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'(i);
    prog_rvalid_out = 1'b0;
    prog_rdata_out  = 16'h0000;
  end

  assign rdata_out = mem[rd_addr_in];

  // Random stall per word; bus toggles between words so stale data shows
  always @(posedge mclk_in)
  begin
    if (we_in)
      mem[waddr_in] <= wdata_in;
    prog_rvalid_out <= 1'b0;
    prog_rdata_out  <= ~prog_rdata_out;
    if (prog_re_in && !prog_rvalid_out && $urandom_range(2) == 0)
    begin
      prog_rvalid_out <= 1'b1;
      prog_rdata_out  <= prog_addr_in ^ 16'hc3a5;
    end
  end
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin \
  n_checks++; \
  if ((s) !== (e)) \
  begin \
    error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); \
  end \
end

// ----
// Bench top
// ----
module tb_top;
  logic              mclk_in = 1'b0;
  logic              srst_in = 1'b1;
  xexec_pkg::instr_t instr = '0;
  logic [7:0]        ptr_hi = 8'h00;
  logic [7:0]        rdata, waddr, wdata, wreg, tab_hi, ptr_lo;
  logic [7:0]        w_e = 8'h00, tab_hi_e = 8'h00, ptr_lo_e = 8'h00;
  logic [15:0]       prdata, paddr;
  logic              prv, we, pre, skip, busy;
  xexec_pkg::flags_t flags, f_e = 6'h00;
  int                error_cnt = 0, n_checks = 0, cyc = 0;

  always #4 mclk_in = ~mclk_in;

  xexec_core xexec_core_i
  (
    .mclk_in (mclk_in), .srst_in (srst_in), .instr_in (instr), .mem_rdata_in (rdata),
    .prog_rdata_in (prdata), .prog_rvalid_in (prv), .table_pointer_high_byte_in (ptr_hi),
    .mem_we_out (we), .mem_waddr_out (waddr), .mem_wdata_out (wdata),
    .prog_re_out (pre), .prog_addr_out (paddr), .working_register_out (wreg),
    .table_high_byte_register_out (tab_hi), .table_pointer_low_byte_out (ptr_lo),
    .flags_out (flags), .skip_out (skip), .busy_out (busy)
  );

  xexec_mem_model xexec_mem_model_i
  (
    .mclk_in (mclk_in), .rd_addr_in (instr.addr), .we_in (we), .waddr_in (waddr),
    .wdata_in (wdata), .rdata_out (rdata), .prog_re_in (pre), .prog_addr_in (paddr),
    .prog_rdata_out (prdata), .prog_rvalid_out (prv)
  );

  // Subtract with optional borrow; returns flags then result
  function automatic logic [13:0] subf(logic [7:0] a, logic [7:0] b, logic brw,
                                       xexec_pkg::flags_t f);
    logic       bi;
    logic [8:0] r;
    logic [4:0] n;
    logic       ofl;
    bi  = brw & ~f[3];
    r   = {1'b0, a} - {1'b0, b} - 9'(bi);
    n   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bi);
    ofl = (a[7] ^ b[7]) & (a[7] ^ r[7]);
    return {(r[7:0] == 8'h00) & (f[1] | !brw), ofl ^ r[7], !r[8], !n[4], r[7:0] == 8'h00, ofl,
            r[7:0]};
  endfunction

  task automatic finish_test();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Issue one operation, predict and compare its effects
  task automatic go(xexec_pkg::op_t op, logic [7:0] a, logic [2:0] b);
    logic [7:0]  m, r;
    logic [15:0] pa;
    logic        sk, mw;
    @(posedge mclk_in);
    instr <= '{1'b1, op, a, b, ~a};
    ptr_hi <= 8'($urandom);
    @(posedge mclk_in);
    m = rdata;
    instr.valid <= 1'b0;
    #1;
    case (op)
      xexec_pkg::OP_SUB_REG, xexec_pkg::OP_SUB_MEM: {f_e, r} = subf(w_e, m, 1'b0, f_e);
      xexec_pkg::OP_SBC_MEM: {f_e, r} = subf(w_e, m, 1'b1, f_e);
      xexec_pkg::OP_DSZ_MEM, xexec_pkg::OP_DSZ_REG: r = m - 8'h01;
      xexec_pkg::OP_ISZ_MEM, xexec_pkg::OP_ISZ_REG: r = m + 8'h01;
      xexec_pkg::OP_SET_BYTE: r = 8'hff;
      xexec_pkg::OP_SET_BIT: r = m | (8'h01 << b);
      xexec_pkg::OP_SWAP_MEM, xexec_pkg::OP_SWAP_REG: r = {m[3:0], m[7:4]};
      default: r = m;
    endcase
    case (op)
      xexec_pkg::OP_DSZ_MEM, xexec_pkg::OP_DSZ_REG, xexec_pkg::OP_ISZ_MEM,
      xexec_pkg::OP_ISZ_REG, xexec_pkg::OP_SZ_BYTE, xexec_pkg::OP_SZA: sk = r == 8'h00;
      xexec_pkg::OP_SNZ_BYTE: sk = m != 8'h00;
      xexec_pkg::OP_SNZ_BIT: sk = m[b];
      xexec_pkg::OP_SZ_BIT: sk = !m[b];
      default: sk = 1'b0;
    endcase
    mw = op inside {xexec_pkg::OP_SBC_MEM, xexec_pkg::OP_SUB_MEM, xexec_pkg::OP_DSZ_MEM,
      xexec_pkg::OP_ISZ_MEM, xexec_pkg::OP_SET_BYTE, xexec_pkg::OP_SET_BIT, xexec_pkg::OP_SWAP_MEM};
    if (op inside {xexec_pkg::OP_SUB_REG, xexec_pkg::OP_DSZ_REG, xexec_pkg::OP_ISZ_REG,
                   xexec_pkg::OP_SWAP_REG, xexec_pkg::OP_SZA})
      w_e = r;
    if (op inside {xexec_pkg::OP_TRD_CUR, xexec_pkg::OP_TRD_LAST, xexec_pkg::OP_TRD_INC})
    begin
      ptr_lo_e = ptr_lo_e + 8'(op == xexec_pkg::OP_TRD_INC);
      pa = {op == xexec_pkg::OP_TRD_CUR ? ~a : op == xexec_pkg::OP_TRD_LAST ? 8'hff : ptr_hi,
            ptr_lo_e};
      `CHK("prog_addr", {1'b1, pa}, {pre, paddr})
      for (int i = 0; i < 40 && !we; i++)
      begin
        @(posedge mclk_in);
        #1;
      end
      {tab_hi_e, r} = pa ^ 16'hc3a5;
      mw = 1'b1;
    end
    `CHK("skip", sk, skip)
    `CHK("busy", sk, busy)
    `CHK("mem_we", mw, we)
    if (mw) `CHK("mem_write", {a, r}, {waddr, wdata})
    `CHK("wreg", w_e, wreg)
    `CHK("flags", f_e, flags)
    `CHK("table", {tab_hi_e, ptr_lo_e}, {tab_hi, ptr_lo})
  endtask

  // Hang guard, far above the expected run length
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'hdcaf));
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    // Zero, wrap and borrow corners first
    go(xexec_pkg::OP_SZ_BYTE, 8'h00, 3'h0);
    go(xexec_pkg::OP_ISZ_REG, 8'hff, 3'h0);
    go(xexec_pkg::OP_DSZ_MEM, 8'h01, 3'h0);
    go(xexec_pkg::OP_SUB_REG, 8'h80, 3'h0);
    go(xexec_pkg::OP_SBC_MEM, 8'h7f, 3'h0);
    // Every operation once, then a random mix
    for (int o = 1; o < 20; o++)
      go(xexec_pkg::op_t'(o), 8'(o * 13), 3'(o));
    repeat (400)
      go(xexec_pkg::op_t'($urandom_range(19, 1)), 8'($urandom), 3'($urandom));
    finish_test();
  end
endmodule
